// file: design/gts_regs_pkg.sv
// Package: register map, field layout and bus carrier types for the GTS control bank
package gts_regs_pkg;
  // Register word indices; the byte address on the bus is 4*index
  localparam logic [7:0] IDX_FIFO_ONE_CTRL  = 8'h1C;
  localparam logic [7:0] IDX_FIFO_TWO_CTRL  = 8'h1D;
  localparam logic [7:0] IDX_SLOT_END_23    = 8'h1E;
  localparam logic [7:0] IDX_SLOT_END_45    = 8'h1F;
  localparam logic [7:0] IDX_FIFO_STATUS    = 8'h30;
  // Field positions inside a FIFO control register
  localparam int RETRY_LSB = 6;
  localparam int SLOT_LSB  = 3;
  localparam int ACK_BIT   = 2;
  localparam int SEC_BIT   = 1;
  localparam int TRIG_BIT  = 0;
  // Field positions inside an end-slot register
  localparam int LOW_END_LSB  = 0;
  localparam int HIGH_END_LSB = 4;
  // Reset values
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] SLOT_END_RESET = 8'h00;
  // Unmapped read answer
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avmm_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
  } avmm_rsp_t;

  // Configuration of one GTS transmit FIFO towards the MAC engine
  typedef struct packed {
    logic [1:0] retry_limit;
    logic [2:0] slot_index;
    logic       ack_request;
    logic       security_enable;
  } fifo_cfg_t;

  // Word-address index of a byte address
  function automatic logic [7:0] word_index(input logic [9:0] addr);
    return addr[9:2];
  endfunction
endpackage

// file: design/gts_tx_fifo_control_slots.sv
// GTS transmit FIFO control and end-slot register bank behind an Avalon-MM slave
// Behaviour
// [RULE1] Written retry field sets transmit retry limit
// [RULE2] Retry read returns retries of last success
// [RULE3] Slot field selects GTS slot for FIFO
// [RULE4] Ack-request bit makes MAC await acknowledgement
// [RULE5] Security-enable bit selects secured transmission
// [RULE6] Trigger starts transmit, hardware clears it
// [RULE7] Upper nibble of first register: third end
// [RULE8] Lower nibble of first register: second end
// [RULE9] Upper nibble of second register: fifth end
// [RULE10] Lower nibble of second register: fourth end
// [RULE11] First FIFO has identical control fields
// [RULE12] End-slot fields are superframe slots 0..15
//
// The Avalon-MM slave port is this design's own decision.
module gts_tx_fifo_control_slots
  import gts_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // Avalon-MM slave
  input  wire gts_regs_pkg::avmm_req_t avs_req,
  output      gts_regs_pkg::avmm_rsp_t avs_rsp,
  // MAC engine side, FIFO one
  output      gts_regs_pkg::fifo_cfg_t fifo_one_cfg,
  output      logic                    fifo_one_start,
  input  wire logic                    fifo_one_done,
  input  wire logic [1:0]              fifo_one_retries_used,
  // MAC engine side, FIFO two
  output      gts_regs_pkg::fifo_cfg_t fifo_two_cfg,
  output      logic                    fifo_two_start,
  input  wire logic                    fifo_two_done,
  input  wire logic [1:0]              fifo_two_retries_used,
  // Superframe slot map
  output      logic [3:0]              second_slot_end,
  output      logic [3:0]              third_slot_end,
  output      logic [3:0]              fourth_slot_end,
  output      logic [3:0]              fifth_slot_end
);
  import gts_regs_pkg::*;

  // Control fields of both FIFOs
  logic [1:0] retry_limit_reg  [2];
  logic [1:0] retry_used_reg   [2];
  logic [2:0] slot_index_reg   [2];
  logic       ack_request_reg  [2];
  logic       sec_enable_reg   [2];
  logic       trigger_reg      [2];
  logic       start_reg        [2];
  logic [1:0] done_cnt_reg     [2];
  logic [7:0] slot_end_23_reg;
  logic [7:0] slot_end_45_reg;
  // Bus handshake state
  logic       ack_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  resp_reg;

  // Decoded request and MAC engine inputs
  logic [7:0] idx;
  logic       req_valid;
  logic       wr_take;
  logic       req_take;
  logic       wr_lane0;
  logic [7:0] wbyte;
  logic       done_in [2];
  logic [1:0] used_in [2];

  assign idx       = word_index(avs_req.address);
  assign req_valid = avs_req.read | avs_req.write;
  // A write commits only in the cycle waitrequest is low, so the register
  // changes at the very edge the master sees the transfer accepted
  assign wr_take   = avs_req.write & ack_reg;
  assign req_take  = req_valid & ~ack_reg;
  assign wr_lane0  = wr_take & avs_req.byteenable[0];
  assign wbyte     = avs_req.writedata[7:0];
  assign done_in[0] = fifo_one_done;
  assign done_in[1] = fifo_two_done;
  assign used_in[0] = fifo_one_retries_used;
  assign used_in[1] = fifo_two_retries_used;

  // Read image of a FIFO control register; the trigger bit is write-only
  function automatic logic [7:0] ctrl_image(input logic [1:0] used, input logic [2:0] slot,
                                            input logic ack, input logic sec);
    logic [7:0] v;
    v = 8'h00;
    v[RETRY_LSB +: 2] = used;                         // [RULE2]
    v[SLOT_LSB +: 3]  = slot;
    v[ACK_BIT]        = ack;
    v[SEC_BIT]        = sec;
    return v;
  endfunction

  // Bus answers one cycle after the request: waitrequest high in the first cycle
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= req_take;
  end

  // Registered waitrequest, the inverse of ack, so the pin leaves a flip-flop
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      wait_reg <= 1'b1;
    else
      wait_reg <= ~req_take;
  end

  // Read data capture, with slave error on unmapped addresses
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= UNMAPPED_DATA;
      resp_reg  <= 2'h0;
    end
    else if (req_take)
    begin
      resp_reg  <= 2'h0;
      rdata_reg <= UNMAPPED_DATA;
      if (idx == IDX_FIFO_ONE_CTRL)
        rdata_reg[7:0] <= ctrl_image(retry_used_reg[0], slot_index_reg[0],
                                     ack_request_reg[0], sec_enable_reg[0]);     // [RULE11]
      else if (idx == IDX_FIFO_TWO_CTRL)
        rdata_reg[7:0] <= ctrl_image(retry_used_reg[1], slot_index_reg[1],
                                     ack_request_reg[1], sec_enable_reg[1]);
      else if (idx == IDX_SLOT_END_23)
        rdata_reg[7:0] <= slot_end_23_reg;
      else if (idx == IDX_SLOT_END_45)
        rdata_reg[7:0] <= slot_end_45_reg;
      else if (idx == IDX_FIFO_STATUS)
        rdata_reg[1:0] <= {trigger_reg[1], trigger_reg[0]};
      else
        resp_reg <= 2'h2;                                  // SLVERR for unmapped
    end
  end

  // Control registers of both FIFOs; same layout for each
  for (genvar f = 0; f < 2; f++)
  begin : g_fifo
    localparam logic [7:0] MY_IDX = (f == 0) ? IDX_FIFO_ONE_CTRL : IDX_FIFO_TWO_CTRL;
    logic hit;
    assign hit = wr_lane0 && (idx == MY_IDX);

    // Static configuration fields
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
      begin
        retry_limit_reg[f] <= CTRL_RESET[RETRY_LSB +: 2];
        slot_index_reg[f]  <= CTRL_RESET[SLOT_LSB +: 3];
        ack_request_reg[f] <= CTRL_RESET[ACK_BIT];
        sec_enable_reg[f]  <= CTRL_RESET[SEC_BIT];
      end
      else if (hit)
      begin
        retry_limit_reg[f] <= wbyte[RETRY_LSB +: 2];      // [RULE1]
        slot_index_reg[f]  <= wbyte[SLOT_LSB +: 3];       // [RULE3]
        ack_request_reg[f] <= wbyte[ACK_BIT];             // [RULE4]
        sec_enable_reg[f]  <= wbyte[SEC_BIT];             // [RULE5]
      end
    end

    // Retry count of the last good frame; written value is not kept here
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        retry_used_reg[f] <= 2'h0;
      else if (done_in[f])
        retry_used_reg[f] <= used_in[f];                  // [RULE2]
    end

    // Trigger: pulse to the MAC, then cleared the cycle after the start pulse; a new trigger wins over the clear
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
      begin
        trigger_reg[f] <= 1'b0;
        start_reg[f]   <= 1'b0;
      end
      else
      begin
        start_reg[f] <= hit & wbyte[TRIG_BIT];            // [RULE6]
        if (hit & wbyte[TRIG_BIT])
          trigger_reg[f] <= 1'b1;
        else if (start_reg[f])
          trigger_reg[f] <= 1'b0;                         // [RULE6]
      end
    end

    // Helper count of completed frames, for coverage only
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        done_cnt_reg[f] <= 2'h0;
      else if (done_in[f])
        done_cnt_reg[f] <= done_cnt_reg[f] + 2'h1;
    end
  end

  // End-slot registers; each nibble is a superframe slot 0..15
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      slot_end_23_reg <= SLOT_END_RESET;
      slot_end_45_reg <= SLOT_END_RESET;
    end
    else if (wr_lane0)
    begin
      if (idx == IDX_SLOT_END_23)
        slot_end_23_reg <= wbyte;                         // [RULE7] [RULE8] [RULE12]
      else if (idx == IDX_SLOT_END_45)
        slot_end_45_reg <= wbyte;                         // [RULE9] [RULE10] [RULE12]
    end
  end

  // Outputs straight from flip-flops
  always_comb
  begin
    avs_rsp.readdata    = rdata_reg;
    avs_rsp.waitrequest = wait_reg;
    avs_rsp.response    = resp_reg;
  end
  assign fifo_one_cfg    = '{retry_limit_reg[0], slot_index_reg[0],
                             ack_request_reg[0], sec_enable_reg[0]};
  assign fifo_two_cfg    = '{retry_limit_reg[1], slot_index_reg[1],
                             ack_request_reg[1], sec_enable_reg[1]};
  assign fifo_one_start  = start_reg[0];
  assign fifo_two_start  = start_reg[1];
  assign second_slot_end = slot_end_23_reg[LOW_END_LSB +: 4];
  assign third_slot_end  = slot_end_23_reg[HIGH_END_LSB +: 4];
  assign fourth_slot_end = slot_end_45_reg[LOW_END_LSB +: 4];
  assign fifth_slot_end  = slot_end_45_reg[HIGH_END_LSB +: 4];

  // Assertions: trigger and start pulse of FIFO two
  a_trig_start_pulse: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
    (g_fifo[1].hit && wbyte[TRIG_BIT]) |=> fifo_two_start ##1 !fifo_two_start)
    else $error("trigger write did not give one start pulse");
  a_trig_self_clear: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
    fifo_two_start && !(g_fifo[1].hit && wbyte[TRIG_BIT]) |=> !trigger_reg[1])
    else $error("trigger bit not cleared by hardware");
  a_trig_pending: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
    (g_fifo[1].hit && wbyte[TRIG_BIT]) |=> trigger_reg[1])
    else $error("trigger write not recorded as pending");

  // Assertions: configuration fields of FIFO two
  a_retry_limit_write: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
    g_fifo[1].hit |=> fifo_two_cfg.retry_limit == $past(wbyte[7:6]))
    else $error("retry limit not written");
  a_cfg_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
    !g_fifo[1].hit |=> $stable(fifo_two_cfg))
    else $error("configuration changed without an accepted write");
  a_retry_read_used: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
    fifo_two_done |=> retry_used_reg[1] == $past(fifo_two_retries_used))
    else $error("retry read not from last success");
  a_slot_index_write: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE3]
    g_fifo[1].hit |=> fifo_two_cfg.slot_index == $past(wbyte[5:3]))
    else $error("slot index not written");
  a_ack_sec_write: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE4]
    g_fifo[1].hit |=> fifo_two_cfg.ack_request == $past(wbyte[2])
      && fifo_two_cfg.security_enable == $past(wbyte[1]))
    else $error("ack or security bit not written");
  a_sec_write: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
    g_fifo[1].hit |=> fifo_two_cfg.security_enable == $past(wbyte[1]))
    else $error("security bit not written");

  // Assertions: FIFO one mirrors FIFO two
  a_fifo_one_same: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
    g_fifo[0].hit |=> fifo_one_cfg.slot_index == $past(wbyte[5:3]))
    else $error("first FIFO slot not written");
  a_fifo_one_start: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
    (g_fifo[0].hit && wbyte[TRIG_BIT]) |=> fifo_one_start ##1 !fifo_one_start)
    else $error("first FIFO trigger did not give one start pulse");
  a_fifo_one_retry: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
    fifo_one_done |=> retry_used_reg[0] == $past(fifo_one_retries_used))
    else $error("first FIFO retry read not from last success");

  // Assertions: end-slot registers
  a_slot_end_23: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE7] [RULE8]
    (wr_lane0 && idx == IDX_SLOT_END_23) |=> {third_slot_end, second_slot_end}
      == $past(wbyte))
    else $error("end slots two and three wrong");
  a_slot_end_45: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE9] [RULE10]
    (wr_lane0 && idx == IDX_SLOT_END_45) |=> {fifth_slot_end, fourth_slot_end}
      == $past(wbyte))
    else $error("end slots four and five wrong");
  a_slot_end_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE12]
    !wr_lane0 |=> $stable(slot_end_23_reg) && $stable(slot_end_45_reg))
    else $error("end slot changed without an accepted write");

  // Assertions: bus handshake
  a_bus_one_wait: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(req_valid) |-> avs_rsp.waitrequest ##1 !avs_rsp.waitrequest)
    else $error("bus answer not after one wait cycle");
  a_read_upper_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    !avs_rsp.waitrequest |-> avs_rsp.readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");

  // Cover main scenarios
  c_trigger_two: cover property (@(posedge mclk) disable iff (sys_rst) fifo_two_start);
  c_trigger_one: cover property (@(posedge mclk) disable iff (sys_rst) fifo_one_start);
  c_done_two: cover property (@(posedge mclk) disable iff (sys_rst) done_cnt_reg[1] == 2'h2);
  c_unmapped: cover property (@(posedge mclk) disable iff (sys_rst) resp_reg == 2'h2);
  c_retry_seen: cover property (@(posedge mclk) disable iff (sys_rst) retry_used_reg[1] != 2'h0);
endmodule

// file: bench/mac_model.sv
// Behavioural MAC engine model answering start pulses with done
module mac_model
  import gts_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  // Register bank side
  input  wire logic                    start,
  input  wire gts_regs_pkg::fifo_cfg_t cfg,
  input  wire logic [3:0]              wait_cycles,
  output      logic                    done,
  output      logic [1:0]              retries_used
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  logic       busy;
  // Frame airtime is set by the bench, so prompt and slow answers both occur
  always_ff @(posedge mclk)
  begin
    done <= 1'b0;
    if (sys_rst)
    begin
      busy <= 1'b0;
      retries_used <= 2'h0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      cnt <= {1'b0, wait_cycles};
    end
    else if (busy && cnt == 5'h0)
    begin
      busy <= 1'b0;
      done <= 1'b1;
      // No ack awaited means no retries; else the full limit is spent
      retries_used <= cfg.ack_request ? cfg.retry_limit : 2'h0;
    end
    else
    begin
      cnt <= cnt - 5'h1;
      // Outside done the value is not held, so stale reads show up
      if (!done)
        retries_used <= ~retries_used;
    end
  end
endmodule

// file: bench/gts_tx_fifo_control_slots_tb.sv
// Self-checking bench for the GTS control and end-slot register bank
module gts_tx_fifo_control_slots_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gts_regs_pkg::*;
  logic      mclk = 1'b0;
  logic      sys_rst = 1'b1;
  avmm_req_t req = '0;
  avmm_rsp_t rsp;
  fifo_cfg_t cfg [2];
  logic      st [2];
  logic      dn [2];
  logic [1:0] ru [2];
  logic [3:0] wt [2] = '{4'h0, 4'h0};
  logic [3:0] se [4];
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [1:0]  ret [2] = '{2'h0, 2'h0};
  int fail_count = 0;
  int check_count = 0;
  int sc [2] = '{0, 0};

  always #10 mclk = ~mclk;
  gts_tx_fifo_control_slots DUT (.mclk(mclk), .sys_rst(sys_rst), .avs_req(req), .avs_rsp(rsp),
    .fifo_one_cfg(cfg[0]), .fifo_one_start(st[0]), .fifo_one_done(dn[0]),
    .fifo_one_retries_used(ru[0]), .fifo_two_cfg(cfg[1]), .fifo_two_start(st[1]),
    .fifo_two_done(dn[1]), .fifo_two_retries_used(ru[1]), .second_slot_end(se[0]),
    .third_slot_end(se[1]), .fourth_slot_end(se[2]), .fifth_slot_end(se[3]));
  mac_model mac_one (.mclk(mclk), .sys_rst(sys_rst), .start(st[0]), .cfg(cfg[0]),
    .wait_cycles(wt[0]), .done(dn[0]), .retries_used(ru[0]));
  mac_model mac_two (.mclk(mclk), .sys_rst(sys_rst), .start(st[1]), .cfg(cfg[1]),
    .wait_cycles(wt[1]), .done(dn[1]), .retries_used(ru[1]));

  // Start pulses are counted so a stretched pulse shows as extra counts
  always @(posedge mclk)
  begin
    if (st[0] === 1'b1) sc[0]++;
    if (st[1] === 1'b1) sc[1]++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon transfer; the request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{address: a, read: !w, write: w, byteenable: be, writedata: {24'h0, d}};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    rd = rsp.readdata;
    rs = rsp.response;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  // Control readback: retries of last success, fields, trigger reads 0
  function automatic logic [31:0] ctrl_exp(input logic [1:0] r, input logic [7:0] d);
    return {24'h0, r, d[5:1], 1'b0};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #100us;
    fail_count++;
    stop_test();
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] e;
    int k;
    int n;
    void'($urandom(32'hBD31));
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      bus(1'b0, 10'h070 + 10'(4 * k), 8'h00, 4'hF);
      check("reset value", rd, 32'h0);
    end
    $display("test reset done");
    // End-slot nibbles, all-zero and all-one corners first
    for (k = 0; k < 12; k++)
    begin
      d = (k < 4) ? {8{k[0]}} : 8'($urandom);
      bus(1'b1, 10'h078 + 10'(4 * k[1]), d, 4'hF);
      bus(1'b0, 10'h078 + 10'(4 * k[1]), 8'h00, 4'hF);
      check("end slot read", rd, {24'h0, d});
      check("end slot out", {se[2 * k[1] + 1], se[2 * k[1]]}, d);
    end
    bus(1'b1, 10'h07C, ~d, 4'h0);
    bus(1'b0, 10'h07C, 8'h00, 4'hF);
    check("masked write", rd, {24'h0, d});
    $display("test end slots done");
    // Control fields of both FIFOs, trigger left clear
    for (k = 0; k < 8; k++)
    begin
      d = 8'($urandom) & 8'hFE;
      bus(1'b1, 10'h070 + 10'(4 * k[0]), d, 4'hF);
      bus(1'b0, 10'h070 + 10'(4 * k[0]), 8'h00, 4'hF);
      check("ctrl read", rd, ctrl_exp(ret[k[0]], d));
      check("cfg out", 32'(cfg[k[0]]), 32'(d[7:1]));
      check("no start", 32'(sc[k[0]]), 32'(0));
    end
    $display("test control done");
    // Trigger, one start pulse, then retries of the finished frame
    for (k = 0; k < 6; k++)
    begin
      d = (k < 2) ? 8'hC5 : (8'($urandom) | 8'h01);
      e = 8'(sc[k[0]]);
      wt[k[0]] <= (k < 2) ? 4'h0 : 4'($urandom);
      bus(1'b1, 10'h070 + 10'(4 * k[0]), d, 4'hF);
      n = 0;
      while (dn[k[0]] !== 1'b1 && n < 40)
      begin
        @(negedge mclk);
        n++;
      end
      if (n >= 40) fail_count++;
      ret[k[0]] = d[2] ? d[7:6] : 2'h0;
      check("start count", 32'(sc[k[0]]), 32'(e) + 32'h1);
      bus(1'b0, 10'h070 + 10'(4 * k[0]), 8'h00, 4'hF);
      check("retry read", rd, ctrl_exp(ret[k[0]], d));
      bus(1'b0, 10'h0C0, 8'h00, 4'hF);
      check("trigger cleared", rd, 32'h0);
    end
    $display("test trigger done");
    bus(1'b1, 10'h3FC, 8'hFF, 4'hF);
    check("unmapped wr resp", 32'(rs), 32'h2);
    bus(1'b0, 10'h3FC, 8'h00, 4'hF);
    check("unmapped rd", {rd[29:0], rs}, 32'h2);
    $display("test unmapped done");
    stop_test();
  end
endmodule
